// ### pkg/lnb_supply_defines.svh
// Purpose: constants for the lnb supply i2c control register block
// Assumes: 7-bit i2c addressing, 8-bit system registers
// Notes: bit positions are within the written data byte
`ifndef LNB_SUPPLY_DEFINES_SVH
`define LNB_SUPPLY_DEFINES_SVH

`define LNB_ADDR_LOW        7'h08
`define LNB_ADDR_HIGH       7'h09
`define LNB_REG_RESET       8'h00
`define LNB_BIT_SELECT      7
`define LNB_BIT_DCL_DIS     6
`define LNB_BIT_ISEL        5
`define LNB_BIT_TONE        4
`define LNB_BIT_COMP        3
`define LNB_BIT_VSEL        2
`define LNB_BIT_EN          1
`define LNB_BIT_OLF         0
`define LNB_BIT_EN2         2
`define LNB_BIT_OTF         1
`define LNB_BITS_PER_BYTE   4'h8

`endif

// ### pkg/lnb_supply_pkg.sv
// Purpose: shared types for the lnb supply i2c control block
// Assumes: nothing beyond the defines header
// Notes: controls travel as one packed struct to the analog side
`default_nettype none
package lnb_supply_pkg;

	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_ADDR   = 3'b001,
		ST_AACK   = 3'b010,
		ST_WDATA  = 3'b011,
		ST_WACK   = 3'b100,
		ST_RDATA  = 3'b101,
		ST_RACK   = 3'b110
	} i2c_state_e;

	typedef enum logic [1:0] {
		VOUT_13V = 2'b00,
		VOUT_18V = 2'b01,
		VOUT_14V = 2'b10,
		VOUT_19V = 2'b11
	} vout_level_e;

	typedef struct packed {
		logic        output_enable;
		logic        second_enable;
		vout_level_e vout_level;
		logic        tone_on;
		logic        high_current_limit;
		logic        static_limit;
	} lnb_ctrl_s;

	typedef struct packed {
		logic scl;
		logic sda;
	} i2c_pins_s;

endpackage
`default_nettype wire

// ### core/lnb_pin_sync.sv
// Purpose: two-flop synchroniser for asynchronous pin inputs
// Assumes: pins are asynchronous to mclk
// Notes: the first stage feeds only the second
`include "lnb_supply_defines.svh"
`default_nettype none
module lnb_pin_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             mclk,   // system clock
	input  wire logic             srst,   // sync reset, active high
	input  wire logic             ce,     // clock enable
	input  wire logic [WIDTH-1:0] d,      // asynchronous input
	output var  logic [WIDTH-1:0] q       // synchronised output
);
	logic [WIDTH-1:0] meta_q;

	always_ff @(posedge mclk) begin
		if (srst) begin
			meta_q <= '1;
			q      <= '1;
		end else if (ce) begin
			meta_q <= d;
			q      <= meta_q;
		end
	end
endmodule
`default_nettype wire

// ### core/lnb_supply_i2c_control_regs.sv
// Purpose: i2c slave and system registers of the lnb supply controller
// Assumes: scl sampled by mclk (25 MHz), scl at most 400 kHz
// Notes: sda is open drain, driven low only while sda_oe is high
//
// Overview of operation
// R1: write-direction address means next data byte writes register chosen by its msb.
// R2: primary register: select, dcl disable, isel, tone, comp, vsel, enable, overload flag.
// R3: secondary register, msb 1: second enable at bit 2, overtemp flag bit 1.
// R4: all register bits clear to zero at power-on.
// R5: vsel and comp pick 13, 18, 14 or 19 volts while enabled.
// R6: continuous tone bit forces tone on; else external tone input gates it.
// R7: current level bit picks lower limit at 0, higher at 1.
// R8: dynamic-limit disable bit 1 selects static clamp, 0 dynamic retry.
// R9: output enable 0 turns off both converter and linear stage.
// R10: read address with direction 1 makes device shift register byte out msb first.
// R11: master ack at ninth clock requests another byte; nack ends the read.
// R12: writable bits read back last written; only the two flags are live.
// R13: overtemp and overload flags read 1 while the condition holds, else 0.
// R14: supply-good low ignores bus and holds registers at zero.
// R15: supply-good high makes the interface operative.
// R16: master sets output enable only once other configuration is valid.
// R17: address select pin low picks low address, high picks high address.
// R18: no acknowledge at all while supply-good is low.
// R19: address lsb 1 read, 0 write; write carries one data byte, each acked.
// R20: writes never alter flags; msb-1 write updates only the second enable.
// R21: address bytes for another address are neither acked nor answered.
`include "lnb_supply_defines.svh"
`default_nettype none
module lnb_supply_i2c_control_regs
	import lnb_supply_pkg::*;
(
	input  wire logic      mclk,          // system clock, 25 MHz
	input  wire logic      srst,          // sync reset, active high
	input  wire logic      ce,            // clock enable, freezes all state
	input  wire logic      scl_i,         // i2c clock pin level
	input  wire logic      sda_i,         // i2c data pin level
	output logic           sda_o,         // sda output value, always low
	output logic           sda_oe,        // sda pull-down enable
	input  wire logic      addr_sel,      // address select pin
	input  wire logic      power_ok,      // supply-good from undervoltage lockout
	input  wire logic      overload,      // overload protection active
	input  wire logic      overtemp,      // thermal shutdown active
	input  wire logic      ext_tone_in,   // external tone gate input
	output lnb_ctrl_s      ctrl,          // decoded controls to power blocks
	output logic           tone_gate,     // 22 kHz tone enable
	output logic           power_enable   // converter and linear stage enable
);
	// pins and status all come from outside the mclk domain
	localparam int NSYNC = 7;
	logic [NSYNC-1:0] raw_in;
	logic [NSYNC-1:0] syn;
	assign raw_in = {scl_i, sda_i, addr_sel, power_ok, overload, overtemp, ext_tone_in};

	lnb_pin_sync #(
		.WIDTH (NSYNC)
	) u_sync (
		.mclk (mclk),
		.srst (srst),
		.ce   (ce),
		.d    (raw_in),
		.q    (syn)
	);

	wire scl_s  = syn[6];
	wire sda_s  = syn[5];
	wire asel_s = syn[4];
	wire pok_s  = syn[3];
	wire olf_s  = syn[2];
	wire otf_s  = syn[1];
	wire tone_s = syn[0];

	logic       scl_q;
	logic       sda_q;
	logic [3:0] bit_cnt_q;
	logic [7:0] shift_q;
	logic [7:0] rd_byte_q;
	logic       rw_q;
	logic       rd_sel_q;
	logic       drive_q;
	i2c_state_e state_q;
	i2c_state_e state_d;

	// writable register bits only; flags are never stored
	logic [5:0] prim_q;  // dcl, isel, tone, comp, vsel, en
	logic       en2_q;
	logic       sel_q;   // register last addressed by a write

	wire scl_rise = scl_s & ~scl_q;
	wire scl_fall = ~scl_s & scl_q;
	wire start_c  = scl_s & scl_q & sda_q & ~sda_s;
	wire stop_c   = scl_s & scl_q & ~sda_q & sda_s;
	wire byte_done = (bit_cnt_q == `LNB_BITS_PER_BYTE);

	wire [6:0] my_addr = asel_s ? `LNB_ADDR_HIGH : `LNB_ADDR_LOW; // [R17]
	wire addr_hit = (shift_q[7:1] == my_addr); // [R21]

	function automatic logic [7:0] read_image(input logic sel, input logic [5:0] p,
		input logic e2, input logic olf, input logic overtemperature_flag);
		logic [7:0] img;
		img = 8'h00;
		if (sel) begin
			img[`LNB_BIT_SELECT] = 1'b1;
			img[`LNB_BIT_EN2]    = e2;
			img[`LNB_BIT_OTF]    = overtemperature_flag; // [R13]
		end else begin
			img[6:1]          = p; // [R12]
			img[`LNB_BIT_OLF] = olf; // [R13]
		end
		return img;
	endfunction

	wire [7:0] rd_image = read_image(rd_sel_q, prim_q, en2_q, olf_s, otf_s);

	// state moves on scl falling edges so sda changes only while scl is low
	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_IDLE:  state_d = ST_IDLE;
			ST_ADDR:  if (scl_fall && byte_done)
					state_d = (addr_hit && pok_s) ? ST_AACK : ST_IDLE; // [R18] [R21]
			ST_AACK:  if (scl_fall)
					state_d = rw_q ? ST_RDATA : ST_WDATA; // [R19] [R10]
			ST_WDATA: if (scl_fall && byte_done)
					state_d = ST_WACK;
			ST_WACK:  if (scl_fall)
					state_d = ST_IDLE; // [R19]
			ST_RDATA: if (scl_fall && byte_done)
					state_d = ST_RACK;
			ST_RACK:  if (scl_fall)
					state_d = rw_q ? ST_RDATA : ST_IDLE; // [R11]
			default:  state_d = ST_IDLE;
		endcase
		if (start_c)
			state_d = ST_ADDR;
		if (stop_c || !pok_s)
			state_d = ST_IDLE; // [R14]
	end

	wire in_byte   = (state_q == ST_ADDR) || (state_q == ST_WDATA) || (state_q == ST_RDATA);
	wire wr_commit = (state_q == ST_WDATA) && scl_fall && byte_done && pok_s; // [R1]

	always_ff @(posedge mclk) begin
		if (srst) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else if (ce) begin
			scl_q <= scl_s;
			sda_q <= sda_s;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			state_q <= ST_IDLE;
		end else if (ce) begin
			state_q <= state_d;
		end
	end

	// bit counter and receive shifter
	always_ff @(posedge mclk) begin
		if (srst) begin
			bit_cnt_q <= 4'h0;
			shift_q   <= 8'h00;
		end else if (ce) begin
			if (start_c || (scl_fall && !in_byte) || (scl_fall && byte_done)) begin
				bit_cnt_q <= 4'h0;
			end else if (scl_rise && in_byte) begin
				bit_cnt_q <= bit_cnt_q + 4'h1;
				shift_q   <= {shift_q[6:0], sda_s}; // msb first
			end
		end
	end

	// direction is latched from the address byte lsb; in read, rw clears on nack
	always_ff @(posedge mclk) begin
		if (srst) begin
			rw_q <= 1'b0;
		end else if (ce) begin
			if (state_q == ST_ADDR && scl_fall && byte_done) begin
				rw_q <= shift_q[0]; // [R19]
			end else if (state_q == ST_RACK && scl_rise && sda_s) begin
				rw_q <= 1'b0; // [R11]
			end
		end
	end

	// write register; power-good low forces every bit to zero
	always_ff @(posedge mclk) begin
		if (srst) begin
			prim_q <= 6'h00; // [R4]
			en2_q  <= 1'b0;
			sel_q  <= 1'b0;
		end else if (ce && !pok_s) begin
			prim_q <= 6'h00; // [R14]
			en2_q  <= 1'b0;
			sel_q  <= 1'b0;
		end else if (ce && wr_commit) begin
			sel_q <= shift_q[`LNB_BIT_SELECT];
			if (shift_q[`LNB_BIT_SELECT]) begin
				en2_q <= shift_q[`LNB_BIT_EN2]; // [R3] [R20]
			end else begin
				prim_q <= shift_q[6:1]; // [R2] [R20]
			end
		end
	end

	// read byte loads at the ack falling edge; register chosen by last write
	always_ff @(posedge mclk) begin
		if (srst) begin
			rd_sel_q  <= 1'b0;
			rd_byte_q <= 8'h00;
		end else if (ce) begin
			rd_sel_q <= sel_q;
			if (scl_fall && state_d == ST_RDATA && state_q != ST_RDATA) begin
				rd_byte_q <= rd_image; // [R10]
			end else if (scl_fall && state_q == ST_RDATA) begin
				rd_byte_q <= {rd_byte_q[6:0], 1'b1};
			end
		end
	end

	// sda pull-down: ack slots, and zero bits of read data
	always_ff @(posedge mclk) begin
		if (srst) begin
			drive_q <= 1'b0;
		end else if (ce) begin
			if (!pok_s || start_c || stop_c) begin
				drive_q <= 1'b0; // [R18]
			end else if (scl_fall) begin
				case (state_d)
					ST_AACK:  drive_q <= 1'b1;
					ST_WACK:  drive_q <= 1'b1;
					ST_RDATA: drive_q <= (state_q == ST_RDATA) ?
						~rd_byte_q[6] : ~rd_image[7]; // [R10]
					default:  drive_q <= 1'b0;
				endcase
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			sda_o  <= 1'b0;
			sda_oe <= 1'b0;
		end else if (ce) begin
			sda_o  <= 1'b0;
			sda_oe <= drive_q;
		end
	end

	// controls to the power blocks; tone gate and stage enable off while disabled
	wire        en_w   = prim_q[0];
	wire [1:0]  lvl_w  = {prim_q[2], prim_q[1]}; // {comp, vsel}
	wire        tone_w = prim_q[3] | tone_s; // [R6]

	always_ff @(posedge mclk) begin
		if (srst) begin
			ctrl         <= '0;
			tone_gate    <= 1'b0;
			power_enable <= 1'b0;
		end else if (ce) begin
			ctrl.output_enable      <= en_w; // [R9]
			ctrl.second_enable      <= en2_q;
			ctrl.vout_level         <= vout_level_e'(lvl_w); // [R5]
			ctrl.tone_on            <= prim_q[3]; // [R6]
			ctrl.high_current_limit <= prim_q[4]; // [R7]
			ctrl.static_limit       <= prim_q[5]; // [R8]
			tone_gate               <= en_w & tone_w; // [R6]
			power_enable            <= en_w & pok_s; // [R9] [R15] [R16]
		end
	end
endmodule
`default_nettype wire

// ### test/lnb_supply_i2c_control_regs_chk.sv
// Purpose: port assertions for the lnb supply register block
// Assumes: bench keeps scl high outside frames and power_ok steady within them
// Notes: bound into every instance of the block
`default_nettype none
module lnb_supply_i2c_control_regs_chk
	import lnb_supply_pkg::*;
(
	input wire logic      mclk,         // system clock
	input wire logic      srst,         // sync reset
	input wire logic      scl_i,        // scl level
	input wire logic      sda_o,        // sda value
	input wire logic      sda_oe,       // sda pull enable
	input wire logic      power_ok,     // supply good
	input wire lnb_ctrl_s ctrl,         // decoded controls
	input wire logic      tone_gate,    // tone enable
	input wire logic      power_enable  // stage enable
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);
	property p_zero; !power_ok [*8] |-> ctrl == 7'h00 && !power_enable; endproperty
	a_zero: assert property (p_zero) else $error("controls not cleared");
	property p_noack; !power_ok [*8] |-> !sda_oe; endproperty
	a_noack: assert property (p_noack) else $error("sda pulled while unpowered");
	property p_tone; (ctrl.output_enable && ctrl.tone_on) [*3] |-> tone_gate; endproperty
	a_tone: assert property (p_tone) else $error("continuous tone missing");
	property p_off; !ctrl.output_enable [*3] |-> !tone_gate && !power_enable; endproperty
	a_off: assert property (p_off) else $error("stage on while disabled");
	property p_pe; power_enable |-> ctrl.output_enable || $past(ctrl.output_enable); endproperty
	a_pe: assert property (p_pe) else $error("stage enable without output enable");
	property p_od; sda_o == 1'b0; endproperty
	a_od: assert property (p_od) else $error("sda driven high");
	property p_slot; $changed(sda_oe) |-> !scl_i; endproperty
	a_slot: assert property (p_slot) else $error("sda moved while scl high");
	// controls may move only in the write ack slot or on loss of supply
	property p_idle; $changed(ctrl) |-> sda_oe || !power_ok; endproperty
	a_idle: assert property (p_idle) else $error("controls moved outside a write ack");
endmodule
bind lnb_supply_i2c_control_regs lnb_supply_i2c_control_regs_chk chk_i (
	.mclk(mclk), .srst(srst), .scl_i(scl_i), .sda_o(sda_o), .sda_oe(sda_oe),
	.power_ok(power_ok), .ctrl(ctrl), .tone_gate(tone_gate), .power_enable(power_enable));
`default_nettype wire

// ### test/lnb_i2c_master.sv
// Purpose: bus master standing in for the host processor
// Assumes: sda pulled up, scl driven only here
// Notes: 320 ns phases honour the 8-cycle minimum of the slave
`default_nettype none
module lnb_i2c_master (
	output var logic scl,    // bus clock
	output var logic sda_m,  // master sda, 0 pulls low
	input wire logic sda_w   // resolved sda wire
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		scl = 1'b1;
		sda_m = 1'b1;
	end
	task automatic bit_x(input logic b, output logic r);
		scl = 1'b0;
		#160 sda_m = b;
		#160 scl = 1'b1;
		#300 r = sda_w;
		#20;
	endtask
	task automatic start;
		#160 sda_m = 1'b0;
		#160;
	endtask
	task automatic stop;
		scl = 1'b0;
		#160 sda_m = 1'b0;
		#160 scl = 1'b1;
		#160 sda_m = 1'b1;
		#160;
	endtask
	// ack_m 0 asks for another byte, 1 ends a read
	task automatic xbyte(input logic [7:0] d, input logic ack_m, output logic [7:0] q,
		output logic ack);
		for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
		bit_x(ack_m, ack);
	endtask
endmodule
`default_nettype wire

// ### test/tb_lnb_supply_i2c_control_regs.sv
// Purpose: self-checking bench for the lnb supply register block
// Assumes: ce held high, stimulus at falling mclk
// Notes: expectations come from a small register model
`default_nettype none
module tb_lnb_supply_i2c_control_regs
	import lnb_supply_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic       mclk, srst, addr_sel, power_ok, overload, overtemp, ext_tone_in;
	logic       scl, sda_m, sda_o, sda_oe, tone_gate, power_enable, ack, e2, sel;
	lnb_ctrl_s  ctrl;
	logic [7:0] p, q;
	int         seed = 15862, fail_count = 0, total_checks = 0;
	wire logic  sda_w = sda_m & ~sda_oe;
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	lnb_supply_i2c_control_regs lnb_supply_i2c_control_regs_i (.mclk(mclk), .srst(srst),
		.ce(1'b1), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe),
		.addr_sel(addr_sel), .power_ok(power_ok), .overload(overload), .overtemp(overtemp),
		.ext_tone_in(ext_tone_in), .ctrl(ctrl), .tone_gate(tone_gate),
		.power_enable(power_enable));
	lnb_i2c_master lnb_i2c_master_i (.scl(scl), .sda_m(sda_m), .sda_w(sda_w));
	task automatic summarize;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [8:0] got, input logic [8:0] exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_ctrl;
		chk({ctrl, tone_gate, power_enable}, {p[1], e2, p[3], p[2], p[4], p[5], p[6],
			p[1] & (p[4] | ext_tone_in), p[1] & power_ok});
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		logic hit;
		hit = power_ok && a == {6'h04, addr_sel};
		lnb_i2c_master_i.start();
		lnb_i2c_master_i.xbyte({a, 1'b0}, 1'b1, q, ack);
		chk(ack, !hit);
		if (hit) begin
			lnb_i2c_master_i.xbyte(d, 1'b1, q, ack);
			chk(ack, 1'b0);
			sel = d[7];
			if (d[7]) e2 = d[2];
			else p = d & 8'h7e;
		end
		lnb_i2c_master_i.stop();
		repeat (10) @(negedge mclk);
		chk_ctrl();
	endtask
	task automatic rd;
		lnb_i2c_master_i.start();
		lnb_i2c_master_i.xbyte({6'h04, addr_sel, 1'b1}, 1'b1, q, ack);
		chk(ack, 1'b0);
		for (int n = 0; n < 2; n++) begin
			lnb_i2c_master_i.xbyte(8'hff, n[0], q, ack);
			chk(q, sel ? {5'h10, e2, overtemp, 1'b0} : {1'b0, p[6:1], overload});
		end
		lnb_i2c_master_i.stop();
		@(negedge mclk);
	endtask
	initial begin
		{srst, power_ok, addr_sel, overload, overtemp, ext_tone_in} = 6'h30;
		{p, e2, sel} = 10'h000;
		repeat (3) @(negedge mclk);
		srst = 1'b0;
		repeat (6) @(negedge mclk);
		chk_ctrl();
		rd();
		$display("reset test done");
		for (int k = 0; k < 12; k++) begin
			{addr_sel, overload, overtemp, ext_tone_in} = 4'($random(seed));
			repeat (6) @(negedge mclk);
			wr({6'h04, addr_sel ^ (k % 4 == 3)}, 8'($random(seed)));
			rd();
		end
		$display("random test done");
		power_ok = 1'b0;
		{p, e2, sel} = 10'h000;
		repeat (8) @(negedge mclk);
		chk_ctrl();
		wr({6'h04, addr_sel}, 8'h02);
		power_ok = 1'b1;
		repeat (6) @(negedge mclk);
		wr({6'h04, addr_sel}, 8'h7e);
		rd();
		$display("power test done");
		summarize();
	end
	initial begin
		#1000000;
		fail_count++;
		$display("[ERR] %0t watchdog expired", $time);
		summarize();
	end
endmodule
`default_nettype wire
